/* hw/crf_map.svh */
// Overview of operation
// - one 8-bit accumulator for results and operands
// - two 8-bit index registers for counts, offsets
// - indexed access adds index register to base
// - pre-indexed and post-indexed addressing both supported
// - 8-bit status register holding seven flags
// - sign in bit 7, overflow in bit 6
// - break flag set to 1 by break op, cleared to 0 on accepted maskable request
// - decimal flag selects decimal arithmetic when set
// - interrupt-disable flag blocks maskable request when set
// - zero and carry flags read 1 when true
// - 16-bit fetch pointer drives address bytes
// - fetch pointer advances after each program fetch
// - 8-bit stack pointer moves on push and pull
// - 128-byte data RAM aliased at 0000H and 0100H
// - 00C0H-00FFH and 0200H-027FH go to peripheral registers
// - 20-byte display RAM at 1000H-1013H, always usable
// - 8K ROM at 4000H-5FFFH for code and tables
`ifndef CRF_MAP_SVH
`define CRF_MAP_SVH
// apb register byte offsets
`define CRF_OFF_ACC      12'h000
`define CRF_OFF_IDX_X    12'h004
`define CRF_OFF_IDX_Y    12'h008
`define CRF_OFF_FLAGS    12'h00C
`define CRF_OFF_PTR      12'h010
`define CRF_OFF_STACK    12'h014
`define CRF_OFF_CMD      12'h018
`define CRF_OFF_ADDR     12'h01C
`define CRF_OFF_REGION   12'h020
// status flag positions
`define CRF_FLG_SIGN     7
`define CRF_FLG_OVF      6
`define CRF_FLG_UNUSED   5
`define CRF_FLG_BRK      4
`define CRF_FLG_DEC      3
`define CRF_FLG_IDIS     2
`define CRF_FLG_ZERO     1
`define CRF_FLG_CARRY    0
// command field positions
`define CRF_CMD_OP_LSB   0
`define CRF_CMD_SEL_BIT  4
`define CRF_CMD_ARG_LSB  8
// address windows
`define CRF_RAM_LO_BASE  16'h0000
`define CRF_RAM_HI_BASE  16'h0100
`define CRF_RAM_SIZE     16'h0080
`define CRF_SFR_A_LO     16'h00C0
`define CRF_SFR_A_HI     16'h00FF
`define CRF_SFR_B_LO     16'h0200
`define CRF_SFR_B_HI     16'h027F
`define CRF_LCD_LO       16'h1000
`define CRF_LCD_HI       16'h1013
`define CRF_ROM_LO       16'h4000
`define CRF_ROM_HI       16'h5FFF
`define CRF_STACK_PAGE   8'h01
// reset values
`define CRF_RST_BYTE     8'h00
`define CRF_RST_PTR      16'h4000
`endif

/* hw/crf_pkg.sv */
package crf_pkg;
    // operations that the register set performs
    typedef enum logic [3:0] {
        CRF_OP_NONE,
        CRF_OP_FETCH,
        CRF_OP_PUSH,
        CRF_OP_PULL,
        CRF_OP_PRE_IDX,
        CRF_OP_POST_IDX,
        CRF_OP_ADD,
        CRF_OP_BRK,
        CRF_OP_IRQ
    } crf_op_e;
    // decoded region of an address
    typedef enum logic [2:0] {
        CRF_RG_NONE,
        CRF_RG_RAM,
        CRF_RG_SFR,
        CRF_RG_LCD,
        CRF_RG_ROM
    } crf_region_e;
    typedef logic [15:0] crf_addr_t;
endpackage : crf_pkg

/* hw/crf_decoder.sv */
`timescale 1ns/1ps
`include "crf_map.svh"
// combinational address space decoder
module crf_decoder
    import crf_pkg::*;
(
    input  wire crf_pkg::crf_addr_t   addr,
    output crf_pkg::crf_region_e      region,
    output logic [6:0]                ram_index
);
    // map address to region and fold ram aliases
    always_comb
    begin
        region = CRF_RG_NONE;
        ram_index = addr[6:0];
        if (addr < `CRF_RAM_SIZE ||
            (addr >= `CRF_RAM_HI_BASE &&
             addr < `CRF_RAM_HI_BASE + `CRF_RAM_SIZE))
            region = CRF_RG_RAM;
        else if ((addr >= `CRF_SFR_A_LO && addr <= `CRF_SFR_A_HI) ||
                 (addr >= `CRF_SFR_B_LO && addr <= `CRF_SFR_B_HI))
            region = CRF_RG_SFR;
        else if (addr >= `CRF_LCD_LO && addr <= `CRF_LCD_HI)
            region = CRF_RG_LCD;
        else if (addr >= `CRF_ROM_LO && addr <= `CRF_ROM_HI)
            region = CRF_RG_ROM;
    end
endmodule : crf_decoder

/* hw/crf_alu.sv */
`timescale 1ns/1ps
`include "crf_map.svh"
// adder for accumulator updates, binary or decimal
module crf_alu
(
    input  wire logic [7:0] a,
    input  wire logic [7:0] b,
    input  wire logic       carry_in,
    input  wire logic       decimal,
    output logic [7:0]      sum,
    output logic            carry_out,
    output logic            overflow
);
    logic [8:0] bin;
    logic [4:0] lo;
    logic [4:0] hi;
    // binary sum, then bcd correction per nibble
    always_comb
    begin
        bin = {1'b0, a} + {1'b0, b} + {8'h00, carry_in};
        lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, carry_in};
        hi = {1'b0, a[7:4]} + {1'b0, b[7:4]};
        overflow = (a[7] == b[7]) && (bin[7] != a[7]);
        sum = bin[7:0];
        carry_out = bin[8];
        if (decimal)
        begin
            if (lo > 5'd9)
            begin
                lo = lo + 5'd6;
                hi = hi + 5'd1;
            end
            if (hi > 5'd9)
                hi = hi + 5'd6;
            sum = {hi[3:0], lo[3:0]};
            carry_out = hi[4];
        end
    end
endmodule : crf_alu

/* hw/crf_core_regs.sv */
`timescale 1ns/1ps
`include "crf_map.svh"
// programmer register set with address generation over apb
module crf_core_regs
    import crf_pkg::*;
(
    input  wire logic            sys_clk,
    input  wire logic            rst_n,
    input  wire logic            psel,
    input  wire logic            penable,
    input  wire logic            pwrite,
    input  wire logic [11:0]     paddr,
    input  wire logic [31:0]     pwdata,
    output logic [31:0]          prdata,
    output logic                 pready,
    output logic                 pslverr,
    input  wire logic            maskable_request_line,
    output logic                 irq_accept,
    output logic [15:0]          bus_addr,
    output crf_pkg::crf_region_e bus_region,
    output logic [6:0]           bus_ram_index
);
    import crf_pkg::*;

    typedef struct packed {
        logic [7:0]  acc_reg;
        logic [7:0]  idx_x_reg;
        logic [7:0]  idx_y_reg;
        logic [7:0]  flags_reg;
        logic [15:0] ptr_reg;
        logic [7:0]  stack_reg;
        logic [15:0] addr_reg;
        logic        irq_reg;
        logic [31:0] rdata_reg;
        logic        err_reg;
    } crf_state_s;

    crf_state_s state_reg;
    crf_state_s state_next;

    logic        wr_en;
    logic        setup_en;
    crf_op_e     op;
    logic        sel_y;
    logic [15:0] arg;
    logic [7:0]  index_val;
    logic [7:0]  sum;
    logic        carry_out;
    logic        overflow;
    crf_region_e region;
    logic [6:0]  ram_index;

    // zero-wait apb: answer registered at setup, stands at access edge
    assign wr_en = psel && penable && pwrite;
    assign setup_en = psel && !penable;
    assign pready = 1'b1;
    assign pslverr = state_reg.err_reg;
    assign prdata = state_reg.rdata_reg;
    assign irq_accept = state_reg.irq_reg;
    assign bus_addr = state_reg.addr_reg;

    // command word fields
    assign op = crf_op_e'(pwdata[`CRF_CMD_OP_LSB +: 4]);
    assign sel_y = pwdata[`CRF_CMD_SEL_BIT];
    assign arg = pwdata[`CRF_CMD_ARG_LSB +: 16];
    assign index_val = sel_y ? state_reg.idx_y_reg
                             : state_reg.idx_x_reg;

    // address region of the current effective address
    crf_decoder u_dec
    (
        .addr      (state_reg.addr_reg),
        .region    (region),
        .ram_index (ram_index)
    );
    assign bus_region = region;
    assign bus_ram_index = ram_index;

    // accumulator adder
    crf_alu u_alu
    (
        .a         (state_reg.acc_reg),
        .b         (arg[7:0]),
        .carry_in  (state_reg.flags_reg[`CRF_FLG_CARRY]),
        .decimal   (state_reg.flags_reg[`CRF_FLG_DEC]),
        .sum       (sum),
        .carry_out (carry_out),
        .overflow  (overflow)
    );

    // register read mux
    function automatic logic [31:0] read_mux(input logic [11:0] a,
                                             input crf_state_s s,
                                             input crf_region_e r);
        read_mux = 32'h0000_0000;
        unique case (a)
            `CRF_OFF_ACC:    read_mux = {24'h00_0000, s.acc_reg};
            `CRF_OFF_IDX_X:  read_mux = {24'h00_0000, s.idx_x_reg};
            `CRF_OFF_IDX_Y:  read_mux = {24'h00_0000, s.idx_y_reg};
            `CRF_OFF_FLAGS:  read_mux = {24'h00_0000, s.flags_reg};
            `CRF_OFF_PTR:    read_mux = {16'h0000, s.ptr_reg};
            `CRF_OFF_STACK:  read_mux = {24'h00_0000, s.stack_reg};
            `CRF_OFF_ADDR:   read_mux = {16'h0000, s.addr_reg};
            `CRF_OFF_REGION: read_mux = {29'h0000_0000, r};
            default:         read_mux = 32'h0000_0000;
        endcase
    endfunction : read_mux

    // known offset check
    function automatic logic mapped(input logic [11:0] a);
        mapped = (a <= `CRF_OFF_REGION) && (a[1:0] == 2'b00);
    endfunction : mapped

    // next-state logic: register writes and commands
    always_comb
    begin
        state_next = state_reg;
        state_next.irq_reg = 1'b0;
        state_next.err_reg = 1'b0;
        // read data and error prepared in the setup cycle
        if (setup_en)
        begin
            if (!pwrite)
                state_next.rdata_reg = read_mux(paddr, state_reg, region);
            state_next.err_reg = !mapped(paddr);
        end
        if (wr_en)
        begin
            unique case (paddr)
                `CRF_OFF_ACC:
                    state_next.acc_reg = pwdata[7:0];
                `CRF_OFF_IDX_X:
                    state_next.idx_x_reg = pwdata[7:0];
                `CRF_OFF_IDX_Y:
                    state_next.idx_y_reg = pwdata[7:0];
                `CRF_OFF_FLAGS:
                begin
                    // all seven flags writable, bit 5 held zero
                    state_next.flags_reg = pwdata[7:0];
                    state_next.flags_reg[`CRF_FLG_UNUSED] = 1'b0;
                end
                `CRF_OFF_PTR:
                    state_next.ptr_reg = pwdata[15:0];
                `CRF_OFF_STACK:
                    state_next.stack_reg = pwdata[7:0];
                `CRF_OFF_CMD:
                begin
                    unique case (op)
                        CRF_OP_FETCH:
                        begin
                            // pointer bytes drive the address bus
                            state_next.addr_reg = state_reg.ptr_reg;
                            state_next.ptr_reg = state_reg.ptr_reg
                                                 + 16'h0001;
                        end
                        CRF_OP_PUSH:
                        begin
                            state_next.addr_reg = {`CRF_STACK_PAGE,
                                                   state_reg.stack_reg};
                            state_next.stack_reg = state_reg.stack_reg
                                                   - 8'h01;
                        end
                        CRF_OP_PULL:
                        begin
                            state_next.stack_reg = state_reg.stack_reg
                                                   + 8'h01;
                            state_next.addr_reg = {`CRF_STACK_PAGE,
                                state_reg.stack_reg + 8'h01};
                        end
                        CRF_OP_PRE_IDX:
                            // base plus index, then used as address
                            state_next.addr_reg = arg
                                + {8'h00, index_val};
                        CRF_OP_POST_IDX:
                            // zero-page pointer plus index, carry runs into the high byte
                            state_next.addr_reg = {8'h00, arg[7:0]}
                                + {8'h00, index_val};
                        CRF_OP_ADD:
                        begin
                            state_next.acc_reg = sum;
                            state_next.flags_reg[`CRF_FLG_CARRY] =
                                carry_out;
                            state_next.flags_reg[`CRF_FLG_ZERO] =
                                (sum == 8'h00);
                            state_next.flags_reg[`CRF_FLG_SIGN] =
                                sum[7];
                            state_next.flags_reg[`CRF_FLG_OVF] =
                                overflow;
                        end
                        CRF_OP_BRK:
                        begin
                            state_next.flags_reg[`CRF_FLG_BRK] = 1'b1;
                            state_next.flags_reg[`CRF_FLG_IDIS] = 1'b1;
                        end
                        default:
                            state_next.addr_reg = state_reg.addr_reg;
                    endcase
                end
                default:
                    state_next.addr_reg = state_reg.addr_reg;
            endcase
        end
        // maskable request accepted only while not disabled
        if (maskable_request_line &&
            !state_reg.flags_reg[`CRF_FLG_IDIS])
        begin
            state_next.irq_reg = 1'b1;
            state_next.flags_reg[`CRF_FLG_BRK] = 1'b0;
            state_next.flags_reg[`CRF_FLG_IDIS] = 1'b1;
        end
    end

    // state register
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg.acc_reg   <= `CRF_RST_BYTE;
            state_reg.idx_x_reg <= `CRF_RST_BYTE;
            state_reg.idx_y_reg <= `CRF_RST_BYTE;
            state_reg.flags_reg <= `CRF_RST_BYTE;
            state_reg.ptr_reg   <= `CRF_RST_PTR;
            state_reg.stack_reg <= `CRF_RST_BYTE;
            state_reg.addr_reg  <= 16'h0000;
            state_reg.irq_reg   <= 1'b0;
            state_reg.rdata_reg <= 32'h0000_0000;
            state_reg.err_reg   <= 1'b0;
        end
        else
            state_reg <= state_next;
    end
endmodule : crf_core_regs

/* tb/crf_core_regs_props.sv */
`timescale 1ns/1ps
// watches the register port and the decoded address outputs
module crf_core_regs_props
    import crf_pkg::*;
(
    input wire logic        sys_clk,
    input wire logic        rst_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        maskable_request_line,
    input wire logic        irq_accept,
    input wire logic [15:0] bus_addr,
    input wire crf_region_e bus_region,
    input wire logic [6:0]  bus_ram_index
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // accepted command write carrying a given operation
    sequence cmd_s(logic [3:0] op);
        psel && penable && pwrite && paddr == 12'h018 && pwdata[3:0] == op;
    endsequence
    // accepted read of the fetch pointer
    sequence rd_ptr_s;
        psel && penable && !pwrite && paddr == 12'h010;
    endsequence
    a_ram_decode: assert property (
        (bus_addr < 16'h0080 || (bus_addr >= 16'h0100 && bus_addr < 16'h0180))
        |-> bus_region == CRF_RG_RAM && bus_ram_index == bus_addr[6:0])
        else $error("ram window decode wrong");
    a_sfr_decode: assert property (
        ((bus_addr >= 16'h00C0 && bus_addr <= 16'h00FF) ||
         (bus_addr >= 16'h0200 && bus_addr <= 16'h027F))
        |-> bus_region == CRF_RG_SFR) else $error("sfr decode wrong");
    a_lcd_decode: assert property (
        bus_addr >= 16'h1000 && bus_addr <= 16'h1013 |-> bus_region == CRF_RG_LCD)
        else $error("display ram decode wrong");
    a_rom_decode: assert property (
        bus_addr >= 16'h4000 && bus_addr <= 16'h5FFF |-> bus_region == CRF_RG_ROM)
        else $error("rom decode wrong");
    a_fetch_step: assert property (
        cmd_s(4'h1) ##[1:4] rd_ptr_s |-> prdata[15:0] == bus_addr + 16'h0001)
        else $error("pointer did not advance after fetch");
    a_stack_page: assert property (
        cmd_s(4'h2) or cmd_s(4'h3) |=> bus_addr[15:8] == 8'h01)
        else $error("stack access left the stack page");
    a_irq_cause: assert property (
        irq_accept |-> $past(maskable_request_line))
        else $error("accept without request");
    a_irq_once: assert property (
        irq_accept |=> !irq_accept) else $error("accept repeated while disabled");
    a_flag_gap: assert property (
        psel && penable && !pwrite && paddr == 12'h00C |-> prdata[5] == 1'b0)
        else $error("unused status bit reads one");
endmodule : crf_core_regs_props

bind crf_core_regs crf_core_regs_props chk_u (.sys_clk, .rst_n, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .maskable_request_line,
    .irq_accept, .bus_addr, .bus_region, .bus_ram_index);

/* tb/crf_mem_model.sv */
`timescale 1ns/1ps
// far-side memory seen through the decoded address
module crf_mem_model
    import crf_pkg::*;
(
    input wire logic [15:0] bus_addr,
    input wire crf_region_e bus_region,
    input wire logic [6:0]  bus_ram_index,
    output logic [7:0]      mem_byte
);
    logic [7:0] ram [128];
    // preload a pattern that differs from the index itself
    initial
    begin
        for (int k = 0; k < 128; k++)
            ram[k] = 8'(k * 37 + 11);
    end
    // one array serves both ram windows; unselected reads are not stale
    always_comb
    begin
        case (bus_region)
            CRF_RG_RAM: mem_byte = ram[bus_ram_index];
            CRF_RG_ROM: mem_byte = bus_addr[7:0] ^ bus_addr[12:5];
            default:    mem_byte = ~bus_addr[7:0];
        endcase
    end
endmodule : crf_mem_model

/* tb/crf_core_regs_tb.sv */
`timescale 1ns/1ps
// register rows, decode rows, then stack, index, alu, irq, errors
module crf_core_regs_tb;
    import crf_pkg::*;
    typedef struct { logic [11:0] a; logic [31:0] w, e; } crf_row_s;
    logic        sys_clk, rst_n, psel, penable, pwrite, pready, pslverr;
    logic        maskable_request_line, irq_accept, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] bus_addr;
    logic [6:0]  bus_ram_index;
    logic [7:0]  mem_byte;
    crf_region_e bus_region;
    int          n_errors = 0;
    int          cmp_count = 0;
    crf_row_s    rows [7] = '{'{12'h000, 32'hA5A5_015A, 32'h0000_005A},
        '{12'h004, 32'h0000_01FF, 32'h0000_00FF},
        '{12'h008, 32'h0000_0033, 32'h0000_0033},
        '{12'h00C, 32'h0000_00FF, 32'h0000_00DF},
        '{12'h010, 32'h0001_2345, 32'h0000_2345},
        '{12'h014, 32'h0000_0181, 32'h0000_0081},
        '{12'h018, 32'h0000_0000, 32'h0000_0000}};
    crf_addr_t   dec_a [15] = '{16'h007F, 16'h0080, 16'h0100, 16'h017F,
        16'h00C0, 16'h00FF, 16'h0200, 16'h027F, 16'h0280, 16'h1000,
        16'h1013, 16'h1014, 16'h4000, 16'h5FFF, 16'h6000};
    crf_region_e dec_r [15] = '{CRF_RG_RAM, CRF_RG_NONE, CRF_RG_RAM,
        CRF_RG_RAM, CRF_RG_SFR, CRF_RG_SFR, CRF_RG_SFR, CRF_RG_SFR,
        CRF_RG_NONE, CRF_RG_LCD, CRF_RG_LCD, CRF_RG_NONE, CRF_RG_ROM,
        CRF_RG_ROM, CRF_RG_NONE};

    crf_core_regs dut_u (.sys_clk, .rst_n, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .maskable_request_line,
        .irq_accept, .bus_addr, .bus_region, .bus_ram_index);
    crf_mem_model mem_u (.bus_addr, .bus_region, .bus_ram_index, .mem_byte);

    // compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        if (got !== exp)
            n_errors++;
    endtask : chk

    task automatic wrap_up();
        $display("compares %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : wrap_up

    // one apb transfer; read data and error taken at the access edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++)
        begin
            @(posedge sys_clk);
            if (pready === 1'b1)
            begin
                rd = prdata;
                err = pslverr;
                break;
            end
        end
        psel <= 1'b0;
        penable <= 1'b0;
        if (i == 20)
            chk(32'h0, 32'h1);
        if (i == 20)
            wrap_up();
    endtask : apb

    task automatic rdc(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        chk(rd, e);
    endtask : rdc

    task automatic cmd(input logic s, input logic [3:0] o, input logic [15:0] g);
        apb(1'b1, 12'h018, {8'h00, g, 3'b000, s, o});
        @(negedge sys_clk); // registered address settles
    endtask : cmd

    // 200 mhz clock
    initial
    begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    // main sequence
    initial
    begin
        int j;
        int n;
        {rst_n, psel, penable, pwrite, maskable_request_line} = '0;
        paddr = '0;
        pwdata = '0;
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        rdc(12'h00C, 32'h0000_0000);
        rdc(12'h010, 32'h0000_4000);
        $display("reset values done");
        foreach (rows[k])
        begin
            apb(1'b1, rows[k].a, rows[k].w);
            rdc(rows[k].a, rows[k].e);
        end
        $display("register rows done");
        foreach (dec_a[k])
        begin
            apb(1'b1, 12'h010, {16'h0000, dec_a[k]});
            cmd(1'b0, 4'h1, 16'h0000);
            chk(bus_addr, dec_a[k]);
            chk(bus_region, dec_r[k]);
            rdc(12'h010, dec_a[k] + 32'h1);
            if ((dec_a[k] & 16'hFEFF) == 16'h007F)
                chk(mem_byte, 32'h0000_0066);
        end
        $display("decode rows done");
        apb(1'b1, 12'h014, 32'h0000_0000);
        cmd(1'b0, 4'h2, 16'h0000);
        chk(bus_addr, 32'h0000_0100);
        rdc(12'h014, 32'h0000_00FF);
        cmd(1'b0, 4'h3, 16'h0000);
        chk(bus_addr, 32'h0000_0100);
        rdc(12'h014, 32'h0000_0000);
        $display("stack wrap done");
        apb(1'b1, 12'h004, 32'h0000_0010);
        cmd(1'b0, 4'h4, 16'h40F8);
        chk(bus_addr, 32'h0000_4108);
        apb(1'b1, 12'h008, 32'h0000_0020);
        cmd(1'b1, 4'h5, 16'h00F0);
        chk(bus_addr, 32'h0000_0110);
        $display("indexing done");
        apb(1'b1, 12'h00C, 32'h0000_0000);
        apb(1'b1, 12'h000, 32'h0000_007F);
        cmd(1'b0, 4'h6, 16'h0001);
        rdc(12'h000, 32'h0000_0080);
        rdc(12'h00C, 32'h0000_00C0);
        apb(1'b1, 12'h000, 32'h0000_00FF);
        cmd(1'b0, 4'h6, 16'h0001);
        rdc(12'h00C, 32'h0000_0003);
        apb(1'b1, 12'h00C, 32'h0000_0008);
        apb(1'b1, 12'h000, 32'h0000_0009);
        cmd(1'b0, 4'h6, 16'h0001);
        rdc(12'h000, 32'h0000_0010);
        apb(1'b1, 12'h00C, 32'h0000_0000);
        cmd(1'b0, 4'h7, 16'h0000);
        rdc(12'h00C, 32'h0000_0014);
        $display("flags done");
        apb(1'b1, 12'h00C, 32'h0000_0000);
        maskable_request_line <= 1'b1;
        for (j = 0; j < 10 && irq_accept !== 1'b1; j++)
            @(posedge sys_clk) #1;
        chk(irq_accept, 32'h1);
        n = 0;
        for (j = 0; j < 6; j++)
        begin
            @(posedge sys_clk) #1;
            n += (irq_accept === 1'b1);
        end
        chk(n, 32'h0);
        rdc(12'h00C, 32'h0000_0004);
        @(posedge sys_clk);
        maskable_request_line <= 1'b0;
        $display("interrupt done");
        apb(1'b1, 12'h024, 32'h0000_00FF);
        chk(err, 32'h1);
        rdc(12'h002, 32'h0000_0000);
        chk(err, 32'h1);
        $display("refusals done");
        @(posedge sys_clk);
        rst_n <= 1'b0;
        @(posedge sys_clk);
        rst_n <= 1'b1;
        chk(bus_addr, 32'h0000_0000);
        chk(irq_accept, 32'h0);
        rdc(12'h00C, 32'h0000_0000);
        rdc(12'h010, 32'h0000_4000);
        $display("mid reset done");
        wrap_up();
    end
endmodule : crf_core_regs_tb
